// File: nad_map.svh
// Opcode images, widths and reset values for the nibble ALU and port decoder
`ifndef NAD_MAP_SVH
`define NAD_MAP_SVH

// Widths
`define NAD_WORD_W      10
`define NAD_NIB_W       4
`define NAD_TBL_ADDR_W  9
`define NAD_REG_COUNT   16
`define NAD_PORT_COUNT  4

// Extension group inserted by the assembler
`define NAD_EXT_BITS    3'h7

// Accumulator group, 16-bit assembler images
`define NAD_IMG_AND_B0  16'hFBE0
`define NAD_IMG_AND_B1  16'hFAE0
`define NAD_IMG_AND_TH  16'hFAF0
`define NAD_IMG_AND_TL  16'hFBF0
`define NAD_IMG_AND_IM  16'hFBF1
`define NAD_IMG_OR_B0   16'hFDE0
`define NAD_IMG_OR_B1   16'hFCE0
`define NAD_IMG_OR_TH   16'hFCF0
`define NAD_IMG_OR_TL   16'hFDF0
`define NAD_IMG_OR_IM   16'hFDF1
`define NAD_IMG_XOR_B0  16'hF5E0
`define NAD_IMG_XOR_B1  16'hF4E0
`define NAD_IMG_XOR_TH  16'hF4F0
`define NAD_IMG_XOR_TL  16'hF5F0
`define NAD_IMG_XOR_IM  16'hF5F1
`define NAD_IMG_INC     16'hF4F3
`define NAD_IMG_ROT     16'hFCF3
`define NAD_IMG_ROTZ    16'hFEF3

// Port group, base images; pair number is added
`define NAD_IMG_IN_L    16'hFFF8
`define NAD_IMG_IN_H    16'hFEF8
`define NAD_IMG_OUT_L   16'hE5F8
`define NAD_IMG_OUT_H   16'hE4F8
`define NAD_IMG_AND_PL  16'hFBF8
`define NAD_IMG_AND_PH  16'hFAF8
`define NAD_IMG_OR_PL   16'hFDF8
`define NAD_IMG_OR_PH   16'hFCF8
`define NAD_IMG_XOR_PL  16'hF5F8
`define NAD_IMG_XOR_PH  16'hF4F8
`define NAD_IMG_OUT_IMM 16'hE6F8

// Valid port pair numbers
`define NAD_PAIR_A      3'h0
`define NAD_PAIR_B      3'h1
`define NAD_PAIR_C      3'h3
`define NAD_PAIR_D      3'h4

// Reset values
`define NAD_ACC_RST     4'h0
`define NAD_CARRY_RST   1'b0
`define NAD_REG_RST     4'h0
`define NAD_P0_RST      8'hFF
`define NAD_P1_RST      8'hFF
`define NAD_P3_RST      8'h03
`define NAD_P4_RST      8'h26

`endif

// File: nad_pkg.sv
// Types and shared helpers for the nibble ALU and port decoder
package nad_pkg;
  `include "nad_map.svh"

  typedef enum logic [2:0] {
    NAD_ALU_PASS = 3'h0,
    NAD_ALU_AND  = 3'h1,
    NAD_ALU_OR   = 3'h2,
    NAD_ALU_XOR  = 3'h3,
    NAD_ALU_INC  = 3'h4,
    NAD_ALU_ROT  = 3'h5
  } nad_alu_op_t;

  // Strip the two inserted extension groups from a 16-bit image
  function automatic logic [9:0] nad_pack(input logic [15:0] img);
    return {img[12:8], img[4:0]};
  endfunction : nad_pack

  // Map pair number to storage slot
  function automatic logic [1:0] nad_pair_slot(input logic [2:0] pair);
    logic [1:0] slot;
    slot = 2'h0;
    unique case (pair)
      `NAD_PAIR_A: slot = 2'h0;
      `NAD_PAIR_B: slot = 2'h1;
      `NAD_PAIR_C: slot = 2'h2;
      `NAD_PAIR_D: slot = 2'h3;
      default:     slot = 2'h0;
    endcase
    return slot;
  endfunction : nad_pair_slot

  function automatic logic nad_pair_ok(input logic [2:0] pair);
    return (pair == `NAD_PAIR_A) || (pair == `NAD_PAIR_B) ||
           (pair == `NAD_PAIR_C) || (pair == `NAD_PAIR_D);
  endfunction : nad_pair_ok
endpackage : nad_pkg

// File: nad_alu.sv
// Nibble logic unit: AND, OR, XOR, increment, rotate and pass
`timescale 1ns/1ps
module nad_alu
  import nad_pkg::*;
#(
  parameter int NIB_W = 4
) (
  // Operation
  input  nad_alu_op_t            op,
  input  wire logic [NIB_W-1:0]  acc_in,
  input  wire logic [NIB_W-1:0]  operand,
  // Result
  output logic [NIB_W-1:0]       result,
  output logic                   carry_out
);
  always_comb begin
    result    = operand;
    carry_out = 1'b0;
    unique case (op)
      NAD_ALU_PASS: begin
        result    = operand;
        carry_out = 1'b0;
      end
      NAD_ALU_AND: begin
        result    = acc_in & operand;
        carry_out = acc_in[NIB_W-1] & operand[NIB_W-1];
      end
      NAD_ALU_OR: begin
        result    = acc_in | operand;
        carry_out = 1'b0;
      end
      NAD_ALU_XOR: begin
        result    = acc_in ^ operand;
        carry_out = acc_in[NIB_W-1] & operand[NIB_W-1];
      end
      NAD_ALU_INC: begin
        result    = acc_in + NIB_W'(1);
        carry_out = (result == '0);
      end
      NAD_ALU_ROT: begin
        result    = {acc_in[NIB_W-2:0], acc_in[NIB_W-1]};
        carry_out = acc_in[NIB_W-1];
      end
      default: begin
        result    = operand;
        carry_out = 1'b0;
      end
    endcase
  end
endmodule : nad_alu

// File: nad_port_file.sv
// Port register pairs, each a low and a high nibble
`timescale 1ns/1ps
`include "nad_map.svh"
module nad_port_file
  import nad_pkg::*;
#(
  parameter int NIB_W = 4
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Write side
  input  wire logic                  wr_nib_en,
  input  wire logic                  wr_high,
  input  wire logic                  wr_byte_en,
  input  wire logic [1:0]            wr_slot,
  input  wire logic [NIB_W-1:0]      wr_nib,
  input  wire logic [2*NIB_W-1:0]    wr_byte,
  // Read side
  input  wire logic [1:0]            rd_slot,
  input  wire logic                  rd_high,
  output logic [NIB_W-1:0]           rd_nib,
  // Register contents
  output logic [4*NIB_W-1:0]         low_flat,
  output logic [4*NIB_W-1:0]         high_flat
);
  logic [NIB_W-1:0] low_reg  [4];
  logic [NIB_W-1:0] high_reg [4];
  // Reset bytes, slot 0 in the low byte
  localparam logic [31:0] RST_VAL = {`NAD_P4_RST, `NAD_P3_RST, `NAD_P1_RST, `NAD_P0_RST};

  for (genvar i = 0; i < 4; i++) begin : g_pair
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        low_reg[i]  <= NIB_W'(RST_VAL[i*8 +: 4]);
        high_reg[i] <= NIB_W'(RST_VAL[i*8+4 +: 4]);
      end else if (wr_byte_en && wr_slot == 2'(i)) begin
        high_reg[i] <= wr_byte[2*NIB_W-1:NIB_W];
        low_reg[i]  <= wr_byte[NIB_W-1:0];
      end else if (wr_nib_en && wr_slot == 2'(i)) begin
        if (wr_high) begin
          high_reg[i] <= wr_nib;
        end else begin
          low_reg[i] <= wr_nib;
        end
      end
    end
    assign low_flat[i*NIB_W +: NIB_W]  = low_reg[i];
    assign high_flat[i*NIB_W +: NIB_W] = high_reg[i];
  end

  assign rd_nib = rd_high ? high_reg[rd_slot] : low_reg[rd_slot];
endmodule : nad_port_file

// File: nad_decode_core.sv
// Decode and execute for accumulator and port instruction groups
`timescale 1ns/1ps
`include "nad_map.svh"
module nad_decode_core
  import nad_pkg::*;
#(
  parameter int WORD_W     = `NAD_WORD_W,
  parameter int NIB_W      = `NAD_NIB_W,
  parameter int REG_COUNT  = `NAD_REG_COUNT,
  parameter int TBL_ADDR_W = `NAD_TBL_ADDR_W
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Instruction from program memory
  input  wire logic                    instr_valid,
  input  wire logic [WORD_W-1:0]       instr_word,
  input  wire logic [WORD_W-1:0]       operand_word,
  // Table read from program memory
  output logic [TBL_ADDR_W-1:0]        tbl_addr,
  input  wire logic [WORD_W-1:0]       tbl_data,
  // General register loading
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_wr_bank,
  input  wire logic [3:0]              reg_wr_idx,
  input  wire logic [NIB_W-1:0]        reg_wr_data,
  // Core state
  output logic [NIB_W-1:0]             acc,
  output logic                         carry_flag,
  output logic [4*NIB_W-1:0]           port_low_nibble,
  output logic [4*NIB_W-1:0]           port_high_nibble,
  // Status
  output logic                         instr_done,
  output logic                         reset_req,
  output logic                         illegal_instr
);
  localparam logic [1:0] PAGE_SLOT = 2'h2;

  typedef enum logic [2:0] {
    NAD_SRC_BANK = 3'h0,
    NAD_SRC_TBLH = 3'h1,
    NAD_SRC_TBLL = 3'h2,
    NAD_SRC_IMM  = 3'h3,
    NAD_SRC_PORT = 3'h4
  } nad_src_t;

  // Architectural state
  logic [NIB_W-1:0]  acc_reg;
  logic              carry_reg;
  logic [NIB_W-1:0]  acc_next;
  logic              carry_next;
  logic [NIB_W-1:0]  bank_zero_register [REG_COUNT];
  logic [NIB_W-1:0]  bank_one_register  [REG_COUNT];
  logic              instr_done_reg;
  logic              reset_req_reg;
  logic              illegal_reg;

  // Decode results
  nad_alu_op_t       alu_op;
  nad_src_t          src_sel;
  logic              known;
  logic              acc_we;
  logic              carry_we;
  logic              bank_sel;
  logic              port_high_sel;
  logic              port_nib_we;
  logic              port_byte_we;
  logic              rot_zero;
  logic              pair_valid;
  logic [1:0]        pair_slot;

  // Datapath
  logic [NIB_W-1:0]  operand;
  logic [NIB_W-1:0]  alu_result;
  logic              alu_carry;
  logic [NIB_W-1:0]  port_rd_nib;
  logic [NIB_W-1:0]  imm_nibble;
  logic [7:0]        imm_byte;
  logic [3:0]        reg_idx;
  logic [2:0]        pair_num;
  logic              table_page_bit;
  logic [7:0]        table_index_register;
  logic              exec;
  logic              rotz_trap;

  // Whole-word, port-base and register-base matches
  function automatic logic hit_word(input logic [WORD_W-1:0] w, input logic [15:0] img);
    return (img[15:13] == `NAD_EXT_BITS) && (img[7:5] == `NAD_EXT_BITS) &&
           (w == nad_pack(img));
  endfunction : hit_word

  function automatic logic hit_port(input logic [WORD_W-1:0] w, input logic [15:0] img);
    logic [9:0] p;
    p = nad_pack(img);
    return w[9:3] == p[9:3];
  endfunction : hit_port

  function automatic logic hit_reg(input logic [WORD_W-1:0] w, input logic [15:0] img);
    logic [9:0] p;
    p = nad_pack(img);
    return w[9:4] == p[9:4];
  endfunction : hit_reg

  assign reg_idx    = instr_word[3:0];
  assign pair_num   = instr_word[2:0];
  assign pair_valid = nad_pair_ok(pair_num);
  assign pair_slot  = nad_pair_slot(pair_num);
  assign imm_nibble = operand_word[NIB_W-1:0];
  assign imm_byte   = operand_word[7:0];
  assign exec       = instr_valid && known;
  assign rotz_trap  = exec && rot_zero && (acc_reg == '0);

  // Instruction decode
  always_comb begin
    alu_op        = NAD_ALU_PASS;
    src_sel       = NAD_SRC_BANK;
    known         = 1'b1;
    acc_we        = 1'b1;
    carry_we      = 1'b1;
    bank_sel      = 1'b0;
    port_high_sel = 1'b0;
    port_nib_we   = 1'b0;
    port_byte_we  = 1'b0;
    rot_zero      = 1'b0;
    if (hit_word(instr_word, `NAD_IMG_AND_TH)) begin
      alu_op  = NAD_ALU_AND;
      src_sel = NAD_SRC_TBLH;
    end else if (hit_word(instr_word, `NAD_IMG_AND_TL)) begin
      alu_op  = NAD_ALU_AND;
      src_sel = NAD_SRC_TBLL;
    end else if (hit_word(instr_word, `NAD_IMG_AND_IM)) begin
      alu_op  = NAD_ALU_AND;
      src_sel = NAD_SRC_IMM;
    end else if (hit_word(instr_word, `NAD_IMG_OR_TH)) begin
      alu_op  = NAD_ALU_OR;
      src_sel = NAD_SRC_TBLH;
    end else if (hit_word(instr_word, `NAD_IMG_OR_TL)) begin
      alu_op  = NAD_ALU_OR;
      src_sel = NAD_SRC_TBLL;
    end else if (hit_word(instr_word, `NAD_IMG_OR_IM)) begin
      alu_op  = NAD_ALU_OR;
      src_sel = NAD_SRC_IMM;
    end else if (hit_word(instr_word, `NAD_IMG_XOR_TH)) begin
      alu_op  = NAD_ALU_XOR;
      src_sel = NAD_SRC_TBLH;
    end else if (hit_word(instr_word, `NAD_IMG_XOR_TL)) begin
      alu_op  = NAD_ALU_XOR;
      src_sel = NAD_SRC_TBLL;
    end else if (hit_word(instr_word, `NAD_IMG_XOR_IM)) begin
      alu_op  = NAD_ALU_XOR;
      src_sel = NAD_SRC_IMM;
    end else if (hit_word(instr_word, `NAD_IMG_INC)) begin
      alu_op = NAD_ALU_INC;
    end else if (hit_word(instr_word, `NAD_IMG_ROT)) begin
      alu_op = NAD_ALU_ROT;
    end else if (hit_word(instr_word, `NAD_IMG_ROTZ)) begin
      alu_op   = NAD_ALU_ROT;
      rot_zero = 1'b1;
    end else if (hit_reg(instr_word, `NAD_IMG_AND_B0) ||
                 hit_reg(instr_word, `NAD_IMG_AND_B1)) begin
      alu_op   = NAD_ALU_AND;
      bank_sel = hit_reg(instr_word, `NAD_IMG_AND_B1);
    end else if (hit_reg(instr_word, `NAD_IMG_OR_B0) ||
                 hit_reg(instr_word, `NAD_IMG_OR_B1)) begin
      alu_op   = NAD_ALU_OR;
      bank_sel = hit_reg(instr_word, `NAD_IMG_OR_B1);
    end else if (hit_reg(instr_word, `NAD_IMG_XOR_B0) ||
                 hit_reg(instr_word, `NAD_IMG_XOR_B1)) begin
      alu_op   = NAD_ALU_XOR;
      bank_sel = hit_reg(instr_word, `NAD_IMG_XOR_B1);
    end else if (!pair_valid) begin
      known = 1'b0;
    end else if (hit_port(instr_word, `NAD_IMG_IN_L) ||
                 hit_port(instr_word, `NAD_IMG_IN_H)) begin
      alu_op        = NAD_ALU_PASS;
      src_sel       = NAD_SRC_PORT;
      port_high_sel = hit_port(instr_word, `NAD_IMG_IN_H);
    end else if (hit_port(instr_word, `NAD_IMG_OUT_L) ||
                 hit_port(instr_word, `NAD_IMG_OUT_H)) begin
      acc_we        = 1'b0;
      carry_we      = 1'b0;
      port_nib_we   = 1'b1;
      port_high_sel = hit_port(instr_word, `NAD_IMG_OUT_H);
    end else if (hit_port(instr_word, `NAD_IMG_OUT_IMM)) begin
      acc_we       = 1'b0;
      carry_we     = 1'b0;
      port_byte_we = 1'b1;
    end else if (hit_port(instr_word, `NAD_IMG_AND_PL) ||
                 hit_port(instr_word, `NAD_IMG_AND_PH)) begin
      alu_op        = NAD_ALU_AND;
      src_sel       = NAD_SRC_PORT;
      port_high_sel = hit_port(instr_word, `NAD_IMG_AND_PH);
    end else if (hit_port(instr_word, `NAD_IMG_OR_PL) ||
                 hit_port(instr_word, `NAD_IMG_OR_PH)) begin
      alu_op        = NAD_ALU_OR;
      src_sel       = NAD_SRC_PORT;
      port_high_sel = hit_port(instr_word, `NAD_IMG_OR_PH);
    end else if (hit_port(instr_word, `NAD_IMG_XOR_PL) ||
                 hit_port(instr_word, `NAD_IMG_XOR_PH)) begin
      alu_op        = NAD_ALU_XOR;
      src_sel       = NAD_SRC_PORT;
      port_high_sel = hit_port(instr_word, `NAD_IMG_XOR_PH);
    end else begin
      known = 1'b0;
    end
    if (!known) begin
      acc_we   = 1'b0;
      carry_we = 1'b0;
    end
  end

  // Operand select
  always_comb begin
    operand = '0;
    unique case (src_sel)
      NAD_SRC_BANK: operand = bank_sel ? bank_one_register[reg_idx]
                                       : bank_zero_register[reg_idx];
      NAD_SRC_TBLH: operand = tbl_data[7:4];
      NAD_SRC_TBLL: operand = tbl_data[3:0];
      NAD_SRC_IMM:  operand = imm_nibble;
      NAD_SRC_PORT: operand = port_rd_nib;
      default:      operand = '0;
    endcase
  end

  nad_alu #(
    .NIB_W     (NIB_W)
  ) u_alu (
    .op        (alu_op),
    .acc_in    (acc_reg),
    .operand   (operand),
    .result    (alu_result),
    .carry_out (alu_carry)
  );

  nad_port_file #(
    .NIB_W      (NIB_W)
  ) u_ports (
    .clk        (clk),
    .rst        (rst),
    .wr_nib_en  (exec && port_nib_we),
    .wr_high    (port_high_sel),
    .wr_byte_en (exec && port_byte_we),
    .wr_slot    (pair_slot),
    .wr_nib     (acc_reg),
    .wr_byte    (imm_byte),
    .rd_slot    (pair_slot),
    .rd_high    (port_high_sel),
    .rd_nib     (port_rd_nib),
    .low_flat   (port_low_nibble),
    .high_flat  (port_high_nibble)
  );

  // Next accumulator and carry; zero-checking rotate of a zero accumulator freezes both
  always_comb begin
    acc_next   = acc_reg;
    carry_next = carry_reg;
    if (exec && !rotz_trap) begin
      if (acc_we) begin
        acc_next = alu_result;
      end
      if (carry_we) begin
        carry_next = alu_carry;
      end
    end
  end

  // Accumulator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= `NAD_ACC_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Carry flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_reg <= `NAD_CARRY_RST;
    end else begin
      carry_reg <= carry_next;
    end
  end

  // General registers, loaded from outside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        bank_zero_register[i] <= `NAD_REG_RST;
        bank_one_register[i]  <= `NAD_REG_RST;
      end
    end else if (reg_wr_en) begin
      if (reg_wr_bank) begin
        bank_one_register[reg_wr_idx] <= reg_wr_data;
      end else begin
        bank_zero_register[reg_wr_idx] <= reg_wr_data;
      end
    end
  end

  // Completion, reset request and illegal pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_done_reg <= 1'b0;
      reset_req_reg  <= 1'b0;
      illegal_reg    <= 1'b0;
    end else begin
      instr_done_reg <= exec;
      reset_req_reg  <= rotz_trap;
      illegal_reg    <= instr_valid && !known;
    end
  end

  // Table address from page bit and index pair
  assign table_page_bit       = port_high_nibble[PAGE_SLOT*NIB_W];
  assign table_index_register = {bank_one_register[0], bank_zero_register[0]};
  assign tbl_addr             = {table_page_bit, table_index_register};

  assign acc           = acc_reg;
  assign carry_flag    = carry_reg;
  assign instr_done    = instr_done_reg;
  assign reset_req     = reset_req_reg;
  assign illegal_instr = illegal_reg;
endmodule : nad_decode_core

// File: nad_tbl_rom.sv
// Behavioural program memory answering table reads
`timescale 1ns/1ps
module nad_tbl_rom (
  // Table read
  input  wire logic [8:0] addr,
  output logic      [9:0] data
);
  // Nibbles differ and the page bit inverts the low byte
  assign data = {addr[1:0], {addr[3:0], ~addr[7:4]} ^ {8{addr[8]}}};
endmodule : nad_tbl_rom

// File: nad_decode_core_checker.sv
// Concurrent checks on the decode core ports
`timescale 1ns/1ps
module nad_decode_core_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Instruction side
  input wire logic        instr_valid,
  input wire logic [9:0]  instr_word,
  input wire logic [9:0]  operand_word,
  input wire logic [9:0]  tbl_data,
  // State and status
  input wire logic [3:0]  acc,
  input wire logic        carry_flag,
  input wire logic [15:0] port_low_nibble,
  input wire logic [15:0] port_high_nibble,
  input wire logic        instr_done,
  input wire logic        reset_req,
  input wire logic        illegal_instr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence run(logic [9:0] op);
    instr_valid && instr_word == op;
  endsequence
  or_imm_a: assert property (run(10'h3B1) |=>
    acc == ($past(acc) | $past(operand_word[3:0])) && !carry_flag)
    else $error("Immediate OR result wrong");
  and_imm_a: assert property (run(10'h371) |=>
    acc == ($past(acc) & $past(operand_word[3:0]))
    && carry_flag == ($past(acc[3]) & $past(operand_word[3])))
    else $error("Immediate AND result wrong");
  xor_tbl_a: assert property (run(10'h290) |=> acc == ($past(acc) ^ $past(tbl_data[7:4]))
    && carry_flag == ($past(acc[3]) & $past(tbl_data[7])))
    else $error("Table XOR result wrong");
  inc_wrap_a: assert property (run(10'h293) |=>
    acc == $past(acc) + 4'h1 && carry_flag == (acc == 4'h0))
    else $error("Increment result wrong");
  rot_left_a: assert property (run(10'h393) |=>
    acc == {$past(acc[2:0]), $past(acc[3])} && carry_flag == $past(acc[3]))
    else $error("Rotate result wrong");
  rotz_zero_a: assert property (run(10'h3D3) ##0 acc == 4'h0 |=>
    reset_req && acc == 4'h0 && $stable(carry_flag))
    else $error("Zero rotate did not request reset");
  bad_pair_a: assert property (instr_valid && instr_word[9:3] == 7'h7F &&
    instr_word[2:0] inside {3'h2, 3'h5, 3'h6, 3'h7} |=>
    illegal_instr && !instr_done && $stable(acc) && $stable(port_low_nibble))
    else $error("Bad port pair not refused");
  imm_byte_a: assert property (run(10'h0DB) |=>
    {port_high_nibble[11:8], port_low_nibble[11:8]} == $past(operand_word[7:0])
    && $stable(carry_flag))
    else $error("Immediate port byte wrong");
  out_keep_a: assert property (run(10'h0B8) |=>
    port_low_nibble[3:0] == $past(acc) && $stable(carry_flag))
    else $error("Port write wrong or carry moved");
  done_pulse_a: assert property (instr_done |-> $past(instr_valid) && !illegal_instr)
    else $error("Done without an instruction");
endmodule : nad_decode_core_checker

bind nad_decode_core nad_decode_core_checker u_chk (
  .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .operand_word(operand_word), .tbl_data(tbl_data), .acc(acc), .carry_flag(carry_flag),
  .port_low_nibble(port_low_nibble), .port_high_nibble(port_high_nibble),
  .instr_done(instr_done), .reset_req(reset_req), .illegal_instr(illegal_instr));

// File: nad_decode_core_tb_top.sv
// Self-checking testbench for the decode core
`timescale 1ns/1ps
module nad_decode_core_tb_top;
  import nad_pkg::*;
  logic        clk, rst, instr_valid, reg_wr_en, reg_wr_bank, e_cy;
  logic        carry_flag, instr_done, reset_req, illegal_instr;
  logic [9:0]  instr_word, operand_word, tbl_data;
  logic [8:0]  tbl_addr;
  logic [3:0]  reg_wr_idx, reg_wr_data, acc, e_acc;
  logic [15:0] port_low_nibble, port_high_nibble;
  int          miscompares, n_checks;
  logic [15:0] rimg [6] = '{16'hFBE0, 16'hFAE0, 16'hFDE0, 16'hFCE0, 16'hF5E0, 16'hF4E0};
  logic [15:0] timg [6] = '{16'hFAF0, 16'hFBF0, 16'hFCF0, 16'hFDF0, 16'hF4F0, 16'hF5F0};
  logic [15:0] pimg [6] = '{16'hFAF8, 16'hFBF8, 16'hFCF8, 16'hFDF8, 16'hF4F8, 16'hF5F8};
  logic [15:0] iimg [3] = '{16'hFBF1, 16'hFDF1, 16'hF5F1};
  logic [2:0]  prs [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

  nad_decode_core dut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .operand_word(operand_word), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
    .reg_wr_en(reg_wr_en), .reg_wr_bank(reg_wr_bank), .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data), .acc(acc), .carry_flag(carry_flag),
    .port_low_nibble(port_low_nibble), .port_high_nibble(port_high_nibble),
    .instr_done(instr_done), .reset_req(reset_req), .illegal_instr(illegal_instr));
  nad_tbl_rom u_rom (.addr(tbl_addr), .data(tbl_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [9:0] pk(input logic [15:0] img);
    return {img[12:8], img[4:0]};
  endfunction : pk
  function automatic logic [9:0] rom(input logic [8:0] a);
    return {a[1:0], {a[3:0], ~a[7:4]} ^ {8{a[8]}}};
  endfunction : rom
  // Carry and result of AND, OR, XOR
  function automatic logic [4:0] lg(input int op, input logic [3:0] a, input logic [3:0] b);
    case (op)
      0: return {a[3] & b[3], a & b};
      1: return {1'b0, a | b};
      default: return {a[3] & b[3], a ^ b};
    endcase
  endfunction : lg

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Issue one instruction at a falling edge, check one cycle later
  task automatic exec(input logic [9:0] w, input logic [9:0] o, input logic bad);
    instr_valid = 1'b1;
    reg_wr_en = 1'b0;
    instr_word = w;
    operand_word = o;
    @(negedge clk);
    chk("done", {15'h0, ~bad}, {15'h0, instr_done});
    chk("illegal", {15'h0, bad}, {15'h0, illegal_instr});
    chk("acc", {12'h0, e_acc}, {12'h0, acc});
    chk("carry", {15'h0, e_cy}, {15'h0, carry_flag});
  endtask : exec
  task automatic wreg(input logic b, input logic [3:0] i, input logic [3:0] d);
    instr_valid = 1'b0;
    reg_wr_en = 1'b1;
    reg_wr_bank = b;
    reg_wr_idx = i;
    reg_wr_data = d;
    @(negedge clk);
  endtask : wreg
  task automatic seta(input logic [3:0] v);
    e_acc = 4'h0;
    e_cy = 1'b0;
    exec(pk(16'hFBF1), 10'h000, 1'b0);
    e_acc = v;
    exec(pk(16'hFDF1), {6'h00, v}, 1'b0);
  endtask : seta
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [3:0]  idx;
    logic [3:0]  nib;
    logic [8:0]  ta;
    logic [7:0]  d8;
    logic [15:0] snap;
    logic [9:0]  rw;
    rst = 1'b1;
    {instr_valid, reg_wr_en, reg_wr_bank, reg_wr_idx, reg_wr_data} = '0;
    instr_word = 10'h000;
    operand_word = 10'h000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk("low_rst", 16'h63FF, port_low_nibble);
    chk("high_rst", 16'h20FF, port_high_nibble);
    chk("addr_rst", 16'h0000, {7'h00, tbl_addr});
    for (int k = 0; k < 6; k++) begin
      idx = 4'hF - 4'(k);
      wreg(1'b0, idx, 4'h9);
      wreg(1'b1, idx, 4'h6);
      seta(4'hC);
      {e_cy, e_acc} = lg(k / 2, 4'hC, k[0] ? 4'h6 : 4'h9);
      exec(pk(rimg[k]) | {6'h00, idx}, 10'h000, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      seta(4'hB);
      {e_cy, e_acc} = lg(k, 4'hB, 4'h9);
      exec(pk(iimg[k]), 10'h3F9, 1'b0);
    end
    wreg(1'b0, 4'h0, 4'hE);
    wreg(1'b1, 4'h0, 4'h8);
    for (int pg = 0; pg < 2; pg++) begin
      if (pg == 1) exec(pk(16'hE6F8) + 10'h003, 10'h013, 1'b0);
      ta = {pg[0], 8'h8E};
      chk("tbl_addr", {7'h00, ta}, {7'h00, tbl_addr});
      for (int k = 0; k < 6; k++) begin
        seta(4'hC);
        rw = rom(ta);
        nib = k[0] ? rw[3:0] : rw[7:4];
        {e_cy, e_acc} = lg(k / 2, 4'hC, nib);
        exec(pk(timg[k]), 10'h000, 1'b0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      d8 = {4'(s + 5), 4'(9 - s)};
      exec(pk(16'hE6F8) + {7'h00, prs[s]}, {2'h3, d8}, 1'b0);
      chk("imm_low", {12'h0, d8[3:0]}, {12'h0, port_low_nibble[4*s +: 4]});
      chk("imm_high", {12'h0, d8[7:4]}, {12'h0, port_high_nibble[4*s +: 4]});
      for (int k = 0; k < 6; k++) begin
        seta(4'hC);
        {e_cy, e_acc} = lg(k / 2, 4'hC, k[0] ? d8[3:0] : d8[7:4]);
        exec(pk(pimg[k]) + {7'h00, prs[s]}, 10'h000, 1'b0);
      end
      seta(4'h8);
      e_cy = 1'b1;
      exec(pk(16'hFBF1), 10'h008, 1'b0);
      {e_cy, e_acc} = {1'b0, d8[3:0]};
      exec(pk(16'hFFF8) + {7'h00, prs[s]}, 10'h000, 1'b0);
      e_acc = d8[7:4];
      exec(pk(16'hFEF8) + {7'h00, prs[s]}, 10'h000, 1'b0);
      seta(4'hA);
      e_cy = 1'b1;
      exec(pk(16'hFBF1), 10'h00F, 1'b0);
      exec(pk(16'hE5F8) + {7'h00, prs[s]}, 10'h000, 1'b0);
      exec(pk(16'hE4F8) + {7'h00, prs[s]}, 10'h000, 1'b0);
      chk("out_low", 16'h000A, {12'h0, port_low_nibble[4*s +: 4]});
      chk("out_high", 16'h000A, {12'h0, port_high_nibble[4*s +: 4]});
    end
    snap = port_low_nibble;
    for (int n = 2; n < 8; n++)
      if (n != 3 && n != 4) exec(pk(16'hFFF8) + 10'(n), 10'h000, 1'b1);
    chk("refused_port", snap, port_low_nibble);
    seta(4'hF);
    {e_cy, e_acc} = 5'h10;
    exec(pk(16'hF4F3), 10'h000, 1'b0);
    seta(4'hE);
    {e_cy, e_acc} = 5'h0F;
    exec(pk(16'hF4F3), 10'h000, 1'b0);
    seta(4'h9);
    {e_cy, e_acc} = 5'h13;
    exec(pk(16'hFCF3), 10'h000, 1'b0);
    seta(4'h4);
    {e_cy, e_acc} = 5'h08;
    exec(pk(16'hFEF3), 10'h000, 1'b0);
    chk("no_reset", 16'h0000, {15'h0, reset_req});
    seta(4'h0);
    exec(pk(16'hFEF3), 10'h000, 1'b0);
    chk("reset_req", 16'h0001, {15'h0, reset_req});
    // Idle cycle lets the checker see the cycle after the trap
    instr_valid = 1'b0;
    @(negedge clk);
    chk("reset_pulse", 16'h0000, {15'h0, reset_req});
    chk("done_idle", 16'h0000, {15'h0, instr_done});
    report_and_stop();
  end
endmodule : nad_decode_core_tb_top
